//--- core/sfp_pkg.sv
package sfp_pkg;

  // =====================================================
  // Command codes
  // =====================================================
  localparam logic [7:0] SFP_CMD_BANK0  = 8'hE0;  // Lower bank select
  localparam logic [7:0] SFP_CMD_BANK1  = 8'hE1;  // Upper bank select
  localparam logic [7:0] SFP_CMD_READ   = 8'h00;  // Read byte
  localparam logic [7:0] SFP_CMD_PROG   = 8'h40;  // Program byte
  localparam logic [7:0] SFP_CMD_VERIFY = 8'hC0;  // Program verify
  localparam logic [7:0] SFP_CMD_ERASE  = 8'h30;  // Auto erase, sent twice
  localparam logic [7:0] SFP_CMD_ERRCHK = 8'h80;  // Error check

  // =====================================================
  // Geometry
  // =====================================================
  localparam int         SFP_BYTE_BITS  = 8;      // Bits per transfer unit
  localparam int         SFP_ADDR_BITS  = 17;     // Two banks of 64 KiB
  localparam int         SFP_MEM_WORDS  = 131072; // Array size in bytes
  localparam logic [7:0] SFP_ERASED     = 8'hFF;  // Erased byte value
  localparam int         SFP_ERR_BIT    = 0;      // Position of command_error_bit

  // =====================================================
  // Timing
  // =====================================================
  localparam int SFP_CLK_MHZ       = 40;                              // System clock rate
  localparam int SFP_PROG_US       = 10;                              // Longest program time
  localparam int SFP_PROG_CYC      = SFP_PROG_US * SFP_CLK_MHZ;       // Rounded down
  localparam int SFP_VRFY_WAIT_US  = 6;                               // Least wait before verify
  localparam int SFP_VRFY_WAIT_CYC = SFP_VRFY_WAIT_US * SFP_CLK_MHZ;  // Rounded up
  localparam int SFP_GAP_NS        = 400;                             // Least gap between bytes
  localparam int SFP_GAP_CYC       = (SFP_GAP_NS * SFP_CLK_MHZ + 999) / 1000;
  // Cycles per half link clock: the returned bit crosses two synchronisers
  // and the device's edge detect, so a shorter half reads stale data
  localparam int SFP_HALF_DIV      = 6;
  localparam int SFP_ERASE_STEP    = 1;                               // Cycles per erased byte
  localparam int SFP_FIFO_DEPTH    = 16;                              // Programmer data FIFO

endpackage : sfp_pkg

//--- core/sfp_link_if.sv
// =====================================================
// Serial programming link between device and programmer
// =====================================================
interface sfp_link_if;
  logic sclk;        // Serial clock, driven by programmer
  logic oe_n;        // Output enable, active low, from programmer
  logic vpp_high;    // Programming supply at programming_voltage_high
  logic busy;        // Busy from device
  logic sda_dev_o;   // Device data out
  logic sda_dev_oe;  // Device drives data
  logic sda_prg_o;   // Programmer data out
  logic sda_prg_oe;  // Programmer drives data
  logic sda;         // Resolved pin level, pulled up when idle

  assign sda = sda_dev_oe ? sda_dev_o : (sda_prg_oe ? sda_prg_o : 1'b1);

  modport device (input sclk, input oe_n, input vpp_high, input sda, output busy, output sda_dev_o,
                  output sda_dev_oe);
  modport programmer (output sclk, output oe_n, output vpp_high, input sda, input busy, output sda_prg_o,
                      output sda_prg_oe);
endinterface : sfp_link_if

//--- core/sfp_fifo.sv
// =====================================================
// Synchronous FIFO with valid/ready on both sides
// =====================================================
module sfp_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 16
) (
  input  wire logic             sys_clk,
  input  wire logic             rst_n,
  input  wire logic [WIDTH-1:0] in_data,
  input  wire logic             in_valid,
  output logic                  in_ready,
  output logic [WIDTH-1:0]      out_data,
  output logic                  out_valid,
  input  wire logic             out_ready
);
  localparam int AW = $clog2(DEPTH);

  logic [WIDTH-1:0] mem_q [DEPTH];  // Storage
  logic [AW-1:0]    wp_q, wp_d;     // Write pointer
  logic [AW-1:0]    rp_q, rp_d;     // Read pointer
  logic [AW:0]      cnt_q, cnt_d;   // Fill level
  logic             push;
  logic             pop;

  assign in_ready  = (cnt_q != (AW+1)'(DEPTH));
  assign out_valid = (cnt_q != '0);
  assign out_data  = mem_q[rp_q];
  assign push      = in_valid && in_ready;
  assign pop       = out_valid && out_ready;

  // Next pointers and level
  always_comb begin
    wp_d  = push ? wp_q + AW'(1) : wp_q;
    rp_d  = pop ? rp_q + AW'(1) : rp_q;
    cnt_d = cnt_q + (AW+1)'(push) - (AW+1)'(pop);
  end

  // Register pointers
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      wp_q  <= '0;
      rp_q  <= '0;
      cnt_q <= '0;
    end else begin
      wp_q  <= wp_d;
      rp_q  <= rp_d;
      cnt_q <= cnt_d;
    end
  end

  // Storage write, no reset needed
  always_ff @(posedge sys_clk) begin
    if (push) begin
      mem_q[wp_q] <= in_data;
    end
  end
endmodule // sfp_fifo

//--- core/sfp_device.sv
// How it works
// - SDA, SCLK, OE high at supply rise enter mode
// - Bytes shift least significant bit first
// - Input bits sampled on rising serial clock
// - Output bits driven on falling serial clock
// - Eight-bit units, command first then operands
// - E0 selects lower bank, E1 upper
// - Bank persists until next bank select or mode entry
// - Lower bank selected on mode entry
// - Erase and error check ignore bank
// - Read: command, low, high address, OE low
// - OE high then clocks shift byte out
// - Program starts on last data rising edge
// - Busy high while programming, within 10 us
// - Verify is a separate request after program, no retry on mismatch
// - Verify reads last programmed address back
// - Erase is 30 twice, busy throughout
// - Erase iterates internally until array erased
// - Error check shifts error byte, bit0 command error
// - Unknown command locks out serial circuit
// - Supply drop resets circuit, keeps error flag
// - Error flag cleared only by completed check
// - Programmer waits 6 us and 400 ns
module sfp_device (
  input  wire logic sys_clk,
  input  wire logic rst_n,
  sfp_link_if.device lnk
);
  import sfp_pkg::*;

  typedef enum logic [3:0] {
    SFP_OFF, SFP_ENTRY, SFP_CMD, SFP_ADL, SFP_ADH, SFP_DATA, SFP_ERA2,
    SFP_WAIT_OE, SFP_LOADOUT, SFP_SHIFT, SFP_PROG, SFP_ERASE, SFP_LOCK
  } sfp_dev_e;

  // =====================================================
  // Pin synchronisers
  // =====================================================
  logic [1:0] clk_s_q, oe_s_q, vpp_s_q, sda_s_q;  // Two-stage chains
  logic       clk_d1_q;                           // Previous synced clock
  logic       rise, fall;

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      clk_s_q  <= 2'h3;
      oe_s_q   <= 2'h3;
      vpp_s_q  <= 2'h0;
      sda_s_q  <= 2'h3;
      clk_d1_q <= 1'b1;
    end else begin
      clk_s_q  <= {clk_s_q[0], lnk.sclk};
      oe_s_q   <= {oe_s_q[0], lnk.oe_n};
      vpp_s_q  <= {vpp_s_q[0], lnk.vpp_high};
      sda_s_q  <= {sda_s_q[0], lnk.sda};
      clk_d1_q <= clk_s_q[1];
    end
  end
  assign rise = clk_s_q[1] && !clk_d1_q;
  assign fall = !clk_s_q[1] && clk_d1_q;

  // =====================================================
  // Flash array
  // =====================================================
  logic [7:0]               mem_q [SFP_MEM_WORDS];  // Flash contents
  logic                     mem_we;                 // Write strobe
  logic [SFP_ADDR_BITS-1:0] mem_wa;                 // Write address
  logic [7:0]               mem_wd;                 // Write data

  always_ff @(posedge sys_clk) begin
    if (mem_we) begin
      mem_q[mem_wa] <= mem_wd;
    end
  end

  // =====================================================
  // Sequencer state
  // =====================================================
  sfp_dev_e                 st_q, st_d;        // Main state
  logic [7:0]               sh_q, sh_d;        // Shift register
  logic [2:0]               bit_q, bit_d;      // Bit index
  logic                     bank_q, bank_d;    // Selected bank
  logic [15:0]              adr_q, adr_d;      // Operand address
  logic [SFP_ADDR_BITS-1:0] padr_q, padr_d;    // Last programmed address
  logic [7:0]               pdat_q, pdat_d;    // Data to program
  logic                     err_q, err_d;      // Command error flag, kept over mode exit
  logic                     ck_q, ck_d;        // Output is error byte
  logic                     rdv_q, rdv_d;      // Output is verify byte
  logic [16:0]              tmr_q, tmr_d;      // Program and erase timer
  logic                     busy_q, busy_d;    // Busy pin register
  logic                     so_q, so_d;        // Data out
  logic                     soe_q, soe_d;      // Data out enable
  logic [7:0]               byte_in;

  assign byte_in = {sda_s_q[1], sh_q[7:1]};

  // Next-state logic
  always_comb begin
    st_d   = st_q;
    sh_d   = sh_q;
    bit_d  = bit_q;
    bank_d = bank_q;
    adr_d  = adr_q;
    padr_d = padr_q;
    pdat_d = pdat_q;
    err_d  = err_q;
    ck_d   = ck_q;
    rdv_d  = rdv_q;
    tmr_d  = tmr_q;
    busy_d = busy_q;
    so_d   = so_q;
    soe_d  = soe_q;
    mem_we = 1'b0;
    mem_wa = padr_q;
    mem_wd = pdat_q;
    if (!vpp_s_q[1]) begin
      // Supply low: serial circuit reset, error flag kept
      st_d   = SFP_OFF;
      busy_d = 1'b0;
      soe_d  = 1'b0;
    end else begin
      case (st_q)
        SFP_OFF: begin
          if (clk_s_q[1] && oe_s_q[1] && sda_s_q[1]) begin
            st_d   = SFP_ENTRY;
            bank_d = 1'b0;
          end
        end
        SFP_ENTRY: begin
          st_d  = SFP_CMD;
          bit_d = 3'h0;
        end
        SFP_CMD, SFP_ADL, SFP_ADH, SFP_DATA, SFP_ERA2: begin
          if (rise) begin
            sh_d  = byte_in;
            bit_d = bit_q + 3'h1;
            if (bit_q == 3'h7) begin
              case (st_q)
                SFP_CMD: begin
                  case (byte_in)
                    SFP_CMD_BANK0:  bank_d = 1'b0;
                    SFP_CMD_BANK1:  bank_d = 1'b1;
                    SFP_CMD_READ:   st_d = SFP_ADL;
                    SFP_CMD_PROG:   st_d = SFP_ADL;
                    SFP_CMD_ERASE:  st_d = SFP_ERA2;
                    SFP_CMD_VERIFY: begin
                      rdv_d = 1'b1;
                      st_d  = SFP_WAIT_OE;
                    end
                    SFP_CMD_ERRCHK: begin
                      sh_d  = 8'h00;
                      sh_d[SFP_ERR_BIT] = err_q;
                      ck_d  = 1'b1;
                      st_d  = SFP_SHIFT;
                    end
                    default: begin
                      err_d = 1'b1;
                      st_d  = SFP_LOCK;
                    end
                  endcase
                  pdat_d = byte_in;
                end
                SFP_ADL: begin
                  adr_d[7:0] = byte_in;
                  st_d       = SFP_ADH;
                end
                SFP_ADH: begin
                  adr_d[15:8] = byte_in;
                  rdv_d       = 1'b0;
                  st_d        = (pdat_q == SFP_CMD_PROG) ? SFP_DATA : SFP_WAIT_OE;
                end
                SFP_DATA: begin
                  pdat_d = byte_in;
                  padr_d = {bank_q, adr_q};
                  busy_d = 1'b1;
                  tmr_d  = 17'(SFP_PROG_CYC - 1);
                  st_d   = SFP_PROG;
                end
                default: begin
                  if (byte_in == SFP_CMD_ERASE) begin
                    busy_d = 1'b1;
                    tmr_d  = '0;
                    st_d   = SFP_ERASE;
                  end else begin
                    err_d = 1'b1;
                    st_d  = SFP_LOCK;
                  end
                end
              endcase
            end
          end
        end
        SFP_WAIT_OE: begin
          if (!oe_s_q[1]) begin
            st_d = SFP_LOADOUT;
          end
        end
        SFP_LOADOUT: begin
          // Fetch into the data latch every cycle while OE is low, then shift once it returns high
          sh_d = rdv_q ? mem_q[padr_q] : mem_q[{bank_q, adr_q}];
          if (oe_s_q[1]) begin
            bit_d = 3'h0;
            st_d  = SFP_SHIFT;
          end
        end
        SFP_SHIFT: begin
          if (fall) begin
            so_d  = sh_q[bit_q];
            soe_d = 1'b1;
          end else if (rise) begin
            bit_d = bit_q + 3'h1;
            if (bit_q == 3'h7) begin
              soe_d = 1'b0;
              if (ck_q) begin
                err_d = 1'b0;
              end
              ck_d = 1'b0;
              st_d = SFP_CMD;
            end
          end
        end
        SFP_PROG: begin
          if (tmr_q == '0) begin
            mem_we = 1'b1;
            busy_d = 1'b0;
            st_d   = SFP_CMD;
            bit_d  = 3'h0;
          end else begin
            tmr_d = tmr_q - 17'h1;
          end
        end
        SFP_ERASE: begin
          // Walk the whole array regardless of bank
          mem_we = 1'b1;
          mem_wa = tmr_q;
          mem_wd = SFP_ERASED;
          tmr_d  = tmr_q + 17'h1;
          if (tmr_q == 17'(SFP_MEM_WORDS - 1)) begin
            busy_d = 1'b0;
            st_d   = SFP_CMD;
            bit_d  = 3'h0;
          end
        end
        SFP_LOCK: begin
          st_d = SFP_LOCK;
        end
        default: st_d = SFP_OFF;
      endcase
    end
  end

  // Register sequencer state
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      st_q   <= SFP_OFF;
      sh_q   <= 8'h00;
      bit_q  <= 3'h0;
      bank_q <= 1'b0;
      adr_q  <= 16'h0000;
      padr_q <= '0;
      pdat_q <= 8'h00;
      err_q  <= 1'b0;
      ck_q   <= 1'b0;
      rdv_q  <= 1'b0;
      tmr_q  <= '0;
      busy_q <= 1'b0;
      so_q   <= 1'b0;
      soe_q  <= 1'b0;
    end else begin
      st_q   <= st_d;
      sh_q   <= sh_d;
      bit_q  <= bit_d;
      bank_q <= bank_d;
      adr_q  <= adr_d;
      padr_q <= padr_d;
      pdat_q <= pdat_d;
      err_q  <= err_d;
      ck_q   <= ck_d;
      rdv_q  <= rdv_d;
      tmr_q  <= tmr_d;
      busy_q <= busy_d;
      so_q   <= so_d;
      soe_q  <= soe_d;
    end
  end

  assign lnk.busy       = busy_q;
  assign lnk.sda_dev_o  = so_q;
  assign lnk.sda_dev_oe = soe_q;
endmodule // sfp_device

//--- core/sfp_programmer.sv
// =====================================================
// Programmer end: runs one operation per user request
// =====================================================
module sfp_programmer (
  input  wire logic        sys_clk,
  input  wire logic        rst_n,
  input  wire logic        supply_on,   // Level: hold supply at programming_voltage_high
  input  wire logic [7:0]  op_cmd,      // Command code
  input  wire logic [15:0] op_addr,     // Address for read and program
  input  wire logic [7:0]  op_data,     // Data for program
  input  wire logic        op_valid,
  output logic             op_ready,
  output logic [7:0]       rd_data,     // Byte read from device
  output logic             rd_valid,
  input  wire logic        rd_ready,
  output logic             dev_busy,    // Synced busy
  sfp_link_if.programmer lnk
);
  import sfp_pkg::*;

  typedef enum logic [2:0] {
    SFP_P_IDLE, SFP_P_SEND, SFP_P_GAP, SFP_P_OE, SFP_P_RECV, SFP_P_WAITB
  } sfp_prg_e;

  logic [1:0] busy_s_q, sda_s_q;  // Pin synchronisers
  logic       fifo_in_ready, fifo_wr;
  logic       push_q, push_d;
  logic [7:0] rx_q, rx_d;

  sfp_fifo #(.WIDTH(8), .DEPTH(SFP_FIFO_DEPTH)) u_rx_fifo (
    .sys_clk   (sys_clk),
    .rst_n     (rst_n),
    .in_data   (rx_q),
    .in_valid  (push_q),
    .in_ready  (fifo_in_ready),
    .out_data  (rd_data),
    .out_valid (rd_valid),
    .out_ready (rd_ready)
  );
  assign fifo_wr = push_q && fifo_in_ready;

  sfp_prg_e    st_q, st_d;
  logic [31:0] seq_q, seq_d;  // Queued bytes, low first
  logic [2:0]  nby_q, nby_d;  // Bytes remaining
  logic        rx_q_f, rx_d_f;  // Receive after sending
  logic        oe_q_f, oe_d_f;  // Pulse OE low before receive
  logic        wb_q, wb_d;    // Wait busy after
  logic [2:0]  bit_q, bit_d;
  logic [3:0]  div_q, div_d;
  logic [8:0]  gap_q, gap_d;
  logic        ck_q, ck_d, oe_q, oe_d, so_q, so_d, soe_q, soe_d;

  always_comb begin
    st_d = st_q; seq_d = seq_q; nby_d = nby_q; rx_d_f = rx_q_f; oe_d_f = oe_q_f; wb_d = wb_q;
    bit_d = bit_q; div_d = div_q; gap_d = gap_q; ck_d = ck_q; oe_d = oe_q; so_d = so_q;
    soe_d = soe_q; rx_d = rx_q; push_d = push_q && !fifo_wr;
    case (st_q)
      SFP_P_IDLE: begin
        if (op_valid && supply_on && fifo_in_ready && !push_q) begin
          seq_d  = {op_data, op_addr[15:8], op_addr[7:0], op_cmd};
          nby_d  = (op_cmd == SFP_CMD_READ) ? 3'h3 : (op_cmd == SFP_CMD_PROG) ? 3'h4 :
                   (op_cmd == SFP_CMD_ERASE) ? 3'h2 : 3'h1;
          if (op_cmd == SFP_CMD_ERASE) seq_d[15:8] = SFP_CMD_ERASE;
          rx_d_f = (op_cmd == SFP_CMD_READ) || (op_cmd == SFP_CMD_VERIFY) || (op_cmd == SFP_CMD_ERRCHK);
          oe_d_f = (op_cmd == SFP_CMD_READ) || (op_cmd == SFP_CMD_VERIFY);
          wb_d   = (op_cmd == SFP_CMD_PROG) || (op_cmd == SFP_CMD_ERASE);
          bit_d = 3'h0; div_d = '0; st_d = SFP_P_SEND;
        end
      end
      SFP_P_SEND, SFP_P_RECV: begin
        div_d = div_q + 4'h1;
        if (div_q == 4'(SFP_HALF_DIV - 1)) begin
          div_d = '0;
          ck_d  = !ck_q;
          if (ck_q) begin
            // Falling edge: present next bit
            soe_d = (st_q == SFP_P_SEND);
            so_d  = seq_q[bit_q];
          end else begin
            // Rising edge: device samples when sending, we sample when receiving
            if (st_q == SFP_P_RECV) rx_d = {sda_s_q[1], rx_q[7:1]};
            bit_d = bit_q + 3'h1;
            if (bit_q == 3'h7) begin
              if (st_q == SFP_P_RECV) begin
                push_d = 1'b1; st_d = SFP_P_GAP; nby_d = 3'h0; rx_d_f = 1'b0;
              end else begin
                seq_d = {8'h00, seq_q[31:8]}; nby_d = nby_q - 3'h1; st_d = SFP_P_GAP;
              end
              gap_d = 9'(SFP_GAP_CYC);
            end
          end
        end
      end
      SFP_P_GAP: begin
        soe_d = 1'b0;
        if (gap_q != '0) gap_d = gap_q - 9'h1;
        else if (nby_q != 3'h0) st_d = SFP_P_SEND;
        else if (oe_q_f) begin
          oe_d = 1'b0; oe_d_f = 1'b0; gap_d = 9'(SFP_GAP_CYC); st_d = SFP_P_OE;
        end else if (rx_q_f) st_d = SFP_P_RECV;
        else if (wb_q) st_d = SFP_P_WAITB;
        else st_d = SFP_P_IDLE;
      end
      SFP_P_OE: begin
        if (gap_q != '0) gap_d = gap_q - 9'h1;
        else begin
          oe_d = 1'b1; gap_d = 9'(SFP_GAP_CYC); st_d = SFP_P_GAP;
        end
      end
      SFP_P_WAITB: begin
        // Settle past busy rise, then wait for it to drop
        if (gap_q != '0) gap_d = gap_q - 9'h1;
        else if (!busy_s_q[1]) begin
          wb_d = 1'b0; gap_d = 9'(SFP_VRFY_WAIT_CYC); st_d = SFP_P_GAP;
        end
      end
      default: st_d = SFP_P_IDLE;
    endcase
    if (st_q == SFP_P_GAP && st_d == SFP_P_WAITB) gap_d = 9'(SFP_GAP_CYC);
  end

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      busy_s_q <= 2'h0; sda_s_q <= 2'h3; st_q <= SFP_P_IDLE; seq_q <= '0; nby_q <= '0;
      rx_q_f <= 1'b0; oe_q_f <= 1'b0; wb_q <= 1'b0; bit_q <= '0; div_q <= '0; gap_q <= '0;
      ck_q <= 1'b1; oe_q <= 1'b1; so_q <= 1'b1; soe_q <= 1'b0; rx_q <= '0; push_q <= 1'b0;
    end else begin
      busy_s_q <= {busy_s_q[0], lnk.busy}; sda_s_q <= {sda_s_q[0], lnk.sda};
      st_q <= st_d; seq_q <= seq_d; nby_q <= nby_d; rx_q_f <= rx_d_f; oe_q_f <= oe_d_f;
      wb_q <= wb_d; bit_q <= bit_d; div_q <= div_d; gap_q <= gap_d; ck_q <= ck_d; oe_q <= oe_d;
      so_q <= so_d; soe_q <= soe_d; rx_q <= rx_d; push_q <= push_d;
    end
  end

  assign op_ready       = (st_q == SFP_P_IDLE) && supply_on && fifo_in_ready && !push_q;
  assign dev_busy       = busy_s_q[1];
  assign lnk.sclk       = ck_q;
  assign lnk.oe_n       = oe_q;
  assign lnk.vpp_high   = supply_on;
  assign lnk.sda_prg_o  = so_q;
  assign lnk.sda_prg_oe = soe_q;
endmodule // sfp_programmer

//--- tb/sfp_link_props.sv
// =====================================================
// Link checker beside the interface
// =====================================================
module sfp_link_props (
  input wire logic sys_clk,
  input wire logic rst_n,
  input wire logic sclk,
  input wire logic oe_n,
  input wire logic vpp_high,
  input wire logic busy,
  input wire logic sda_dev_o,
  input wire logic sda_dev_oe,
  input wire logic sda_prg_o,
  input wire logic sda_prg_oe,
  input wire logic sda
);
  // One domain: system clock, async reset
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!rst_n);

  dev_bit_edge_a: assert property (sda_dev_oe && $changed(sda_dev_o) |-> !sclk)
    else $error("device data moved while serial clock high");
  dev_turn_on_a: assert property ($rose(sda_dev_oe) |-> !sclk && oe_n)
    else $error("device drive began at wrong moment");
  oe_low_quiet_a: assert property (!oe_n |-> !sda_dev_oe)
    else $error("device drove data with output enable low");
  single_driver_a: assert property (!(sda_dev_oe && sda_prg_oe))
    else $error("both ends drive data");
  busy_quiet_a: assert property (busy |-> !sda_dev_oe)
    else $error("device drove data while busy");
  busy_launch_a: assert property ($rose(busy) |-> sclk && vpp_high)
    else $error("busy rose away from a rising clock");
  busy_stands_a: assert property ($rose(busy) |=> busy [*8])
    else $error("busy dropped too soon");
  supply_off_quiet_a: assert property (!vpp_high [*4] |-> !sda_dev_oe)
    else $error("device drove data with supply low");
  prg_setup_a: assert property (sda_prg_oe && $changed(sda_prg_o) |-> !sclk)
    else $error("programmer data moved while serial clock high");
  mode_entry_a: assert property ($rose(vpp_high) |-> sclk && oe_n && sda)
    else $error("supply raised with link lines not high");
endmodule // sfp_link_props

//--- tb/test_serial_flash_programming_port.sv
// =====================================================
// Bench: programmer user side, both ends joined
// =====================================================
module test_serial_flash_programming_port;
  timeunit 1ns;
  timeprecision 1ps;
  import sfp_pkg::*;
  logic        sys_clk   = 1'b0;  // System clock
  logic        rst_n     = 1'b0;  // Async reset
  logic        supply_on = 1'b0;  // Supply level request
  logic        op_valid  = 1'b0;  // Request strobe
  logic        rd_ready  = 1'b1;  // Read drain
  logic [7:0]  op_cmd    = 8'h00; // Command
  logic [15:0] op_addr   = 16'h0000; // Address
  logic [7:0]  op_data   = 8'h00; // Data
  logic [7:0]  rd_data;           // Returned byte
  logic        op_ready, rd_valid, dev_busy;
  logic [7:0]  sniff_q   = 8'h00; // Wire byte, LSB first
  int          bad_count = 0;
  int          checked   = 0;
  int          cyc       = 0;
  sfp_link_if lnk ();
  sfp_device sfp_device_inst (.sys_clk(sys_clk), .rst_n(rst_n), .lnk(lnk));
  sfp_programmer sfp_programmer_inst (.sys_clk(sys_clk), .rst_n(rst_n), .supply_on(supply_on),
    .op_cmd(op_cmd), .op_addr(op_addr), .op_data(op_data), .op_valid(op_valid), .op_ready(op_ready),
    .rd_data(rd_data), .rd_valid(rd_valid), .rd_ready(rd_ready), .dev_busy(dev_busy), .lnk(lnk));
  sfp_link_props sfp_link_props_inst (.sys_clk(sys_clk), .rst_n(rst_n), .sclk(lnk.sclk), .oe_n(lnk.oe_n),
    .vpp_high(lnk.vpp_high), .busy(lnk.busy), .sda_dev_o(lnk.sda_dev_o), .sda_dev_oe(lnk.sda_dev_oe),
    .sda_prg_o(lnk.sda_prg_o), .sda_prg_oe(lnk.sda_prg_oe), .sda(lnk.sda));
  // Clock and wire sniffer
  initial forever #12.5 sys_clk = ~sys_clk;
  always @(posedge lnk.sclk) sniff_q <= {lnk.sda, sniff_q[7:1]};
  // Hang guard
  always @(posedge sys_clk) begin
    cyc <= cyc + 1;
    if (cyc == 40000) begin
      bad_count++;
      test_done();
    end
  end
  task automatic cmp8(input logic [7:0] got, input logic [7:0] exp);
    checked++;
    if (got !== exp) begin
      bad_count++;
      $display("Error at %0t: byte %h, expected %h", $time, got, exp);
    end
  endtask
  task automatic cmp1(input logic got, input logic exp);
    checked++;
    if (got !== exp) begin
      bad_count++;
      $display("Error at %0t: flag %b, expected %b", $time, got, exp);
    end
  endtask
  // Issue one operation; taken when ready seen high
  task automatic op(input logic [7:0] c, input logic [15:0] a, input logic [7:0] d);
    int n = 0;
    @(posedge sys_clk);
    op_cmd <= c;
    op_addr <= a;
    op_data <= d;
    op_valid <= 1'b1;
    do begin @(negedge sys_clk); n++; end while (op_ready !== 1'b1 && n < 20000);
    @(posedge sys_clk);
    op_valid <= 1'b0;
  endtask
  task automatic idle();
    int n = 0;
    do begin @(negedge sys_clk); n++; end while (op_ready !== 1'b1 && n < 20000);
  endtask
  task automatic get(input logic [7:0] e);
    int n = 0;
    do begin @(negedge sys_clk); n++; end while (rd_valid !== 1'b1 && n < 20000);
    cmp8(rd_data, e);
    @(posedge sys_clk);
  endtask
  task automatic t_first_check();
    op(SFP_CMD_ERRCHK, 16'h0000, 8'h00);
    get(8'h00);
  endtask
  task automatic t_prog_default();
    int n = 0;
    int m = 0;
    op(SFP_CMD_PROG, 16'h0010, 8'h3C);
    do begin @(negedge sys_clk); m++; if (dev_busy === 1'b1) n++; end while (m < 3000 && !(n > 0 && dev_busy !== 1'b1));
    cmp1(n > 0 && n <= SFP_PROG_CYC + 4, 1'b1);
    // Verify may only be offered once the post-program wait has run
    m = 0;
    do begin @(negedge sys_clk); m++; end while (op_ready !== 1'b1 && m < 3000);
    cmp1(m >= SFP_VRFY_WAIT_CYC, 1'b1);
    op(SFP_CMD_VERIFY, 16'h0000, 8'h00);
    get(8'h3C);
  endtask
  task automatic t_banks();
    op(SFP_CMD_BANK1, 16'h0000, 8'h00);
    idle();
    cmp8(sniff_q, SFP_CMD_BANK1);
    op(SFP_CMD_PROG, 16'h0010, 8'h5A);
    op(SFP_CMD_VERIFY, 16'h0000, 8'h00);
    get(8'h5A);
    op(SFP_CMD_READ, 16'h0010, 8'h00);
    get(8'h5A);
    op(SFP_CMD_BANK0, 16'h0000, 8'h00);
    op(SFP_CMD_READ, 16'h0010, 8'h00);
    get(8'h3C);
  endtask
  task automatic t_fifo();
    @(posedge sys_clk);
    rd_ready <= 1'b0;
    repeat (SFP_FIFO_DEPTH) op(SFP_CMD_READ, 16'h0010, 8'h00);
    repeat (600) @(negedge sys_clk);
    cmp1(op_ready, 1'b0);
    @(posedge sys_clk);
    rd_ready <= 1'b1;
    repeat (SFP_FIFO_DEPTH) get(8'h3C);
    idle();
    cmp1(op_ready, 1'b1);
  endtask
  task automatic t_error();
    op(8'h55, 16'h0000, 8'h00);
    op(SFP_CMD_ERRCHK, 16'h0000, 8'h00);
    get(8'hFF);
    @(posedge sys_clk);
    supply_on <= 1'b0;
    repeat (40) @(posedge sys_clk);
    supply_on <= 1'b1;
    op(SFP_CMD_ERRCHK, 16'h0000, 8'h00);
    get(8'h01);
    op(SFP_CMD_ERRCHK, 16'h0000, 8'h00);
    get(8'h00);
  endtask
  task automatic test_done();
    $display("checked %0d bad_count %0d", checked, bad_count);
    if (bad_count == 0 && checked > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask
  // Main sequence
  initial begin
    repeat (4) @(posedge sys_clk);
    rst_n <= 1'b1;
    @(posedge sys_clk);
    supply_on <= 1'b1;
    t_first_check();
    t_prog_default();
    t_banks();
    t_fifo();
    t_error();
    test_done();
  end
endmodule // test_serial_flash_programming_port
